//--- ost_output_unit.sv
// Output unit: send-delay timers, message sequencing and APB registers
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ost_output_unit
  import ost_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Mode controller and receive side
  input  wire logic                 cmd_stb,
  input  wire ost_cmd_t             cmd,
  input  wire logic                 accept_start,
  input  wire logic                 accept_relay,
  // Second schedule stream source
  input  wire logic                 s2_valid,
  input  wire logic [PAYLOAD_W-1:0] s2_data,
  output logic                      s2_ready,
  // Communication module
  output logic                      out_stb,
  output ost_msg_t                  out_msg
);
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // Level must fit the four-bit status field
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 15) begin : g_bad_depth
    $error("FIFO_DEPTH must be 1..15");
  end

  typedef enum logic [3:0] {S_IDLE, S_DIAG, S_SS, S_CD, S_SU1, S_SU2, S_PE} ost_state_t;

  logic [1:0]           ctrl_ff;
  logic [7:0]           su_cnt_ff, pe_cnt_ff;
  logic [CNT_W-1:0]     dly_ff [NUM_DLY];
  logic [31:0]          prdata_ff;
  logic                 pslverr_ff;
  ost_state_t           state_ff;
  logic [7:0]           idx_ff, sent_ff;
  logic                 is_iface;
  logic [CNT_W-1:0]     eff [NUM_DLY];
  logic [CNT_W-1:0]     cnt_ff [2];
  logic                 run_ff [2];
  logic                 start [2], gate [2], again [2], fire [2];
  logic [CNT_W-1:0]     ld [2], reld [2];
  logic                 out_stb_ff;
  ost_msg_t             out_msg_ff;
  logic [PAYLOAD_W-1:0] mem_ff [FIFO_DEPTH];
  logic [PTR_W-1:0]     wr_ptr_ff, rd_ptr_ff;
  logic [LVL_W-1:0]     lvl_ff;
  logic                 push, pop, last_msg;
  logic [7:0]           su_n, pe_n;

  assign is_iface = ctrl_ff[CTRL_IFACE_BIT];

  // APB: no wait states; setup phase prepares the read word
  wire       setup   = psel && !penable;
  wire       acc_wr  = psel && penable && pwrite;
  wire [9:0] widx    = paddr[11:2];
  wire [9:0] didx    = widx - REG_DLY0[11:2];
  wire       dly_hit = paddr >= REG_DLY0 && didx < NUM_DLY[9:0] && paddr[1:0] == 2'h0;
  wire       mapped  = dly_hit || paddr == REG_CTRL || paddr == REG_COUNT || paddr == REG_STATUS;

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !mapped;
      prdata_ff  <= 32'h0000_0000;
      if (dly_hit)
        prdata_ff[CNT_W-1:0] <= dly_ff[didx[3:0]];
      else if (paddr == REG_CTRL)
        prdata_ff[1:0] <= ctrl_ff;
      else if (paddr == REG_COUNT)
        prdata_ff[15:0] <= {pe_cnt_ff, su_cnt_ff};
      else if (paddr == REG_STATUS) begin
        prdata_ff[ST_BUSY_BIT]                <= state_ff != S_IDLE || run_ff[1];
        prdata_ff[ST_STATE_LSB +: 4]          <= state_ff;
        prdata_ff[ST_SENT_LSB +: 8]           <= sent_ff;
        prdata_ff[ST_LVL_LSB +: LVL_W]        <= lvl_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= CTRL_RST;
      su_cnt_ff <= MSG_CNT_RST;
      pe_cnt_ff <= MSG_CNT_RST;
    end else if (acc_wr && paddr == REG_CTRL) begin
      ctrl_ff <= pwdata[1:0];
    end else if (acc_wr && paddr == REG_COUNT) begin
      su_cnt_ff <= pwdata[CNT_SU_LSB +: 8];
      pe_cnt_ff <= pwdata[CNT_PE_LSB +: 8];
    end
  end

  // Delay table; the effective value is raised to its least value
  for (genvar d = 0; d < NUM_DLY; d++) begin : g_dly
    logic [CNT_W-1:0] lo;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        dly_ff[d] <= DLY_RST;
      else if (acc_wr && dly_hit && didx == 10'(d))
        dly_ff[d] <= pwdata[CNT_W-1:0];
    end
    always_comb begin
      lo = DLY_MIN[d];
      if (d == DLY_SS_START && is_iface)
        lo = 16'h0001;
      if (d == DLY_SU_FIRST && !is_iface)
        lo = 16'h0001;
      eff[d] = (dly_ff[d] < lo) ? lo : dly_ff[d];
    end
  end

  assign su_n = (su_cnt_ff == 8'h00) ? 8'h01 : su_cnt_ff;
  assign pe_n = (pe_cnt_ff == 8'h00) ? 8'h01 : pe_cnt_ff;

  // Channel 0 sequences message streams, channel 1 sends relay messages
  wire idle_cmd = state_ff == S_IDLE && cmd_stb;
  always_comb begin
    start[0] = 1'b0;
    ld[0]    = eff[DLY_DIAG];
    if (idle_cmd) begin
      case (cmd)
        CMD_DIAG_INIT: begin
          start[0] = 1'b1;
          ld[0]    = eff[DLY_DIAG];
        end
        CMD_SYNC_PRES: begin
          start[0] = is_iface;
          ld[0]    = eff[DLY_SS_PRES];
        end
        CMD_COLL_DIAG: begin
          start[0] = 1'b1;
          ld[0]    = eff[DLY_CD_FIRST];
        end
        CMD_SCHED: begin
          start[0] = 1'b1;
          ld[0]    = eff[DLY_SU_FIRST];
        end
        CMD_PROC_ELEM: begin
          start[0] = 1'b1;
          ld[0]    = eff[DLY_PE_FIRST];
        end
        default: start[0] = 1'b0;
      endcase
    end else if (state_ff == S_IDLE && !is_iface && accept_start) begin
      start[0] = 1'b1;
      ld[0]    = ctrl_ff[CTRL_PRES_BIT] ? eff[DLY_SS_PRES] : eff[DLY_SS_START];
    end
  end

  // Step that a strobe this cycle belongs to; a zero first delay fires while still idle
  ost_state_t cur_st;
  always_comb begin
    cur_st = state_ff;
    if (state_ff == S_IDLE && start[0] && idle_cmd) begin
      case (cmd)
        CMD_DIAG_INIT: cur_st = S_DIAG;
        CMD_COLL_DIAG: cur_st = S_CD;
        CMD_SCHED:     cur_st = S_SU1;
        CMD_PROC_ELEM: cur_st = S_PE;
        default:       cur_st = S_SS;
      endcase
    end else if (state_ff == S_IDLE && start[0]) begin
      cur_st = S_SS;
    end
  end

  assign last_msg = (cur_st == S_CD  && idx_ff == 8'(NUM_CD - 1))
                 || ((cur_st == S_SU1 || cur_st == S_SU2) && idx_ff == su_n - 8'h01)
                 || (cur_st == S_PE  && idx_ff == pe_n - 8'h01);

  always_comb begin
    again[0] = 1'b0;
    reld[0]  = eff[DLY_CD_NEXT];
    case (cur_st)
      S_DIAG: begin
        again[0] = is_iface;
        reld[0]  = eff[DLY_SS_START];
      end
      S_CD: begin
        again[0] = !last_msg;
        reld[0]  = eff[DLY_CD_NEXT];
      end
      S_SU1: begin
        again[0] = 1'b1;
        reld[0]  = last_msg ? eff[DLY_SU_S2] : eff[DLY_SCHED_MSG_INTERVAL];
      end
      S_SU2: begin
        again[0] = !last_msg;
        reld[0]  = eff[DLY_SCHED_MSG_INTERVAL];
      end
      S_PE: begin
        again[0] = !last_msg;
        reld[0]  = eff[DLY_PROC_ELEM_MSG_INTERVAL];
      end
      default: again[0] = 1'b0;
    endcase
  end

  // Second stream waits for buffered data; relay yields to channel 0
  assign gate[0]  = state_ff != S_SU2 || lvl_ff != '0;
  assign start[1] = is_iface ? accept_start : accept_relay;
  assign ld[1]    = eff[DLY_RELAY];
  assign gate[1]  = !fire[0];
  assign again[1] = 1'b0;
  assign reld[1]  = eff[DLY_RELAY];

  for (genvar c = 0; c < 2; c++) begin : g_tmr
    assign fire[c] = gate[c] && ((start[c] && ld[c] == '0) || (run_ff[c] && cnt_ff[c] == 16'h0001));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_ff[c] <= '0;
        run_ff[c] <= 1'b0;
      end else if (start[c] && (ld[c] != '0 || !gate[c])) begin
        cnt_ff[c] <= (ld[c] == '0) ? 16'h0001 : ld[c];
        run_ff[c] <= 1'b1;
      end else if (fire[c] && again[c]) begin
        cnt_ff[c] <= reld[c];
        run_ff[c] <= 1'b1;
      end else if (fire[c]) begin
        run_ff[c] <= 1'b0;
      end else if (run_ff[c] && cnt_ff[c] != 16'h0001) begin
        cnt_ff[c] <= cnt_ff[c] - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      idx_ff   <= 8'h00;
    end else if (fire[0]) begin
      idx_ff <= idx_ff + 8'h01;
      case (cur_st)
        S_DIAG: begin
          state_ff <= is_iface ? S_SS : S_IDLE;
          idx_ff   <= 8'h00;
        end
        S_SU1: begin
          state_ff <= last_msg ? S_SU2 : S_SU1;
          if (last_msg)
            idx_ff <= 8'h00;
        end
        S_CD, S_SU2, S_PE: begin
          state_ff <= last_msg ? S_IDLE : cur_st;
          if (last_msg)
            idx_ff <= 8'h00;
        end
        default: begin
          state_ff <= S_IDLE;
          idx_ff   <= 8'h00;
        end
      endcase
    end else if (state_ff == S_IDLE) begin
      // A nonzero first delay parks the step here until its timer ends
      idx_ff   <= 8'h00;
      state_ff <= cur_st;
    end
  end

  // Kind of the message strobed on channel 0 this cycle
  ost_kind_t kind0;
  always_comb begin
    case (cur_st)
      S_DIAG:  kind0 = MSG_DIAG;
      S_CD:    kind0 = MSG_COLL_DIAG;
      S_SU1:   kind0 = MSG_SCHED1;
      S_SU2:   kind0 = MSG_SCHED2;
      S_PE:    kind0 = MSG_PROC_ELEM;
      default: kind0 = MSG_SYNC_START;
    endcase
  end

  // Registered stage toward the communication module
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_stb_ff <= 1'b0;
      out_msg_ff <= '0;
      sent_ff    <= 8'h00;
    end else begin
      out_stb_ff <= fire[0] || fire[1];
      if (fire[0]) begin
        out_msg_ff.kind    <= kind0;
        out_msg_ff.payload <= (state_ff == S_SU2) ? mem_ff[rd_ptr_ff] : PAYLOAD_W'(idx_ff);
      end else if (fire[1]) begin
        out_msg_ff.kind    <= MSG_SYNC_RELAY;
        out_msg_ff.payload <= '0;
      end
      if (fire[0] || fire[1])
        sent_ff <= sent_ff + 8'h01;
    end
  end
  assign out_stb = out_stb_ff;
  assign out_msg = out_msg_ff;

  // Second-stream buffer; an entry is readable one tick after its write
  assign s2_ready = lvl_ff != LVL_W'(FIFO_DEPTH);
  assign push     = s2_valid && s2_ready;
  assign pop      = fire[0] && state_ff == S_SU2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      lvl_ff    <= '0;
    end else begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      lvl_ff <= lvl_ff + LVL_W'(push) - LVL_W'(pop);
    end
  end
  always_ff @(posedge pclk) begin
    if (push)
      mem_ff[wr_ptr_ff] <= s2_data;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence strobe_out_s;
    ##1 out_stb_ff;
  endsequence
  // Least value one allows back-to-back strobes, so check the reload instead
  sequence reload_s(logic [CNT_W-1:0] v);
    ##1 run_ff[0] && cnt_ff[0] == v;
  endsequence

  strobe_one_tick_a: assert property ((fire[0] || fire[1]) |-> strobe_out_s) else $error("strobe not registered");
  diag_zero_a: assert property (idle_cmd && cmd == CMD_DIAG_INIT && dly_ff[DLY_DIAG] == '0
    |-> ##1 out_stb_ff && out_msg_ff.kind == MSG_DIAG) else $error("zero diag delay missed");
  relay_ss_a: assert property (state_ff == S_IDLE && !cmd_stb && !is_iface && accept_start && ld[0] == '0
    |-> fire[0]) else $error("relay sync-start late");
  iface_chain_a: assert property (fire[0] && cur_st == S_DIAG && is_iface
    |-> reload_s(eff[DLY_SS_START]) ##0 state_ff == S_SS) else $error("sync-start chain wrong");
  relay_zero_a: assert property (start[1] && ld[1] == '0 && !fire[0] |-> fire[1]) else $error("relay late");
  cd_spacing_a: assert property (fire[0] && cur_st == S_CD && !last_msg
    |-> reload_s(eff[DLY_CD_NEXT])) else $error("cd spacing");
  su_first_a: assert property (idle_cmd && cmd == CMD_SCHED && !is_iface |-> !fire[0]) else $error("su first early");
  su_gap_a: assert property (fire[0] && cur_st == S_SU1 && last_msg
    |-> reload_s(eff[DLY_SU_S2]) ##0 state_ff == S_SU2) else $error("stream gap");
  fifo_tick_a: assert property (lvl_ff == '0 && state_ff == S_SU2 |-> !fire[0]) else $error("unbuffered send");
  sched_msg_interval_a: assert property (fire[0] && cur_st == S_SU2 && !last_msg
    |-> reload_s(eff[DLY_SCHED_MSG_INTERVAL])) else $error("su interval");
  proc_elem_msg_interval_a: assert property (fire[0] && cur_st == S_PE && !last_msg
    |-> reload_s(eff[DLY_PROC_ELEM_MSG_INTERVAL])) else $error("pe interval");
  timer_end_a: assert property (run_ff[0] && cnt_ff[0] == 16'h0002 && gate[0] && !start[0]
    |-> ##1 (fire[0] || !gate[0])) else $error("timer end missed");
endmodule

//--- ost_pkg.sv
// Shared constants and types for the output send timing block
package ost_pkg;
  // Data and timer widths, count of delays and of collision-diagnosis messages
  localparam int CNT_W     = 16;
  localparam int PAYLOAD_W = 16;
  localparam int NUM_DLY   = 11;
  localparam int NUM_CD    = 4;

  // APB register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_COUNT  = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_DLY0   = 12'h040;

  // Control register fields
  localparam int CTRL_IFACE_BIT = 0;
  localparam int CTRL_PRES_BIT  = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Count register fields
  localparam int CNT_SU_LSB = 0;
  localparam int CNT_PE_LSB = 8;
  localparam logic [7:0] MSG_CNT_RST = 8'h04;

  // Status register fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_SENT_LSB  = 8;
  localparam int ST_LVL_LSB   = 16;

  // Delay table indices, each a word at REG_DLY0 + 4*index
  localparam int DLY_DIAG     = 0;
  localparam int DLY_SS_START = 1;
  localparam int DLY_SS_PRES  = 2;
  localparam int DLY_RELAY    = 3;
  localparam int DLY_CD_FIRST = 4;
  localparam int DLY_CD_NEXT  = 5;
  localparam int DLY_SU_FIRST = 6;
  localparam int DLY_SU_S2    = 7;
  localparam int DLY_SCHED_MSG_INTERVAL   = 8;
  localparam int DLY_PE_FIRST = 9;
  localparam int DLY_PROC_ELEM_MSG_INTERVAL   = 10;
  localparam logic [CNT_W-1:0] DLY_RST = 16'h0001;

  // Least values per delay; node-dependent ones are fixed up at use
  localparam logic [CNT_W-1:0] DLY_MIN [NUM_DLY] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
    16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0001};

  typedef enum logic [2:0] {
    CMD_NONE, CMD_DIAG_INIT, CMD_SYNC_PRES, CMD_COLL_DIAG, CMD_SCHED, CMD_PROC_ELEM
  } ost_cmd_t;

  typedef enum logic [2:0] {
    MSG_DIAG, MSG_SYNC_START, MSG_SYNC_RELAY, MSG_COLL_DIAG, MSG_SCHED1, MSG_SCHED2, MSG_PROC_ELEM
  } ost_kind_t;

  typedef struct packed {
    ost_kind_t              kind;
    logic [PAYLOAD_W-1:0]   payload;
  } ost_msg_t;
endpackage

//--- ost_comm_model.sv
// Communication module model: logs each strobed message with its edge number
`timescale 1ns/1ps
module ost_comm_model
  import ost_pkg::*;
(
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // Strobe and message from the output unit
  input  wire logic     out_stb,
  input  wire ost_msg_t out_msg
);
  int       cyc_ff;
  int       stamp_q[$];
  ost_msg_t msg_q[$];

  // Edge numbers let the bench measure each delay to the exact tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 0;
    end else begin
      cyc_ff <= cyc_ff + 1;
      // Strobe counts only when seen at a clock edge
      if (out_stb === 1'b1) begin
        stamp_q.push_back(cyc_ff + 1);
        msg_q.push_back(out_msg);
      end
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the output send timing block
`timescale 1ns/1ps
module tb_top
  import ost_pkg::*;
;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata;
  logic                 cmd_stb, accept_start, accept_relay, s2_valid, s2_ready, out_stb;
  ost_cmd_t             cmd;
  logic [PAYLOAD_W-1:0] s2_data;
  ost_msg_t             out_msg;
  int                   miscompares, n_checks, cycles;

  ost_output_unit #(.FIFO_DEPTH(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_stb(cmd_stb), .cmd(cmd), .accept_start(accept_start), .accept_relay(accept_relay),
    .s2_valid(s2_valid), .s2_data(s2_data), .s2_ready(s2_ready), .out_stb(out_stb), .out_msg(out_msg));

  ost_comm_model comm (.pclk(pclk), .presetn(presetn), .out_stb(out_stb), .out_msg(out_msg));

  always #25 pclk = ~pclk;

  task automatic test_done();
    $display("Checks made: %0d, mismatches: %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard; whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic set_dly(input int i, input int d);
    wr(REG_DLY0 + 12'(4 * i), 32'(d));
  endtask

  // sel bits: relay indication, sync-start indication, command
  task automatic pulse(input logic [2:0] sel, input ost_cmd_t c, output int s);
    @(posedge pclk);
    {accept_relay, accept_start, cmd_stb} <= sel;
    cmd <= c;
    @(negedge pclk);
    // Edge that launches the request; every send delay counts from it
    s = comm.cyc_ff;
    @(posedge pclk);
    {accept_relay, accept_start, cmd_stb} <= 3'b000;
  endtask

  task automatic expect_msg(input int stamp, input ost_kind_t k, input logic [PAYLOAD_W-1:0] p,
                            input logic chk_p);
    ost_msg_t msg;
    int       n;
    n = 0;
    while (comm.msg_q.size() == 0 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    if (comm.msg_q.size() == 0) begin
      check(32'h0, 32'h1);
    end else begin
      check(32'(comm.stamp_q.pop_front()), 32'(stamp));
      msg = comm.msg_q.pop_front();
      check(32'(msg.kind), 32'(k));
      if (chk_p) begin
        check(32'(msg.payload), 32'(p));
      end
    end
  endtask

  // Polls busy, then no stray message may remain
  task automatic wait_idle();
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[ST_BUSY_BIT] !== 1'b0 && n < 200);
    check(32'(r[ST_BUSY_BIT]), 32'h0);
    check(32'(comm.msg_q.size()), 32'h0);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    check(r, 32'(CTRL_RST));
    apb(1'b0, REG_COUNT, 32'h0, r, e);
    check(r, 32'({MSG_CNT_RST, MSG_CNT_RST}));
    apb(1'b0, REG_DLY0 + 12'h028, 32'h0, r, e);
    check(r, 32'(DLY_RST));
    apb(1'b0, 12'h3FC, 32'h0, r, e);
    check(r, 32'h0);
    check(32'(e), 32'h1);
    set_dly(DLY_PROC_ELEM_MSG_INTERVAL, 0);
    apb(1'b0, REG_DLY0 + 12'h028, 32'h0, r, e);
    check(r, 32'h0);
  endtask

  task automatic t_diag();
    int s;
    for (int d = 0; d <= 3; d += 3) begin
      set_dly(DLY_DIAG, d);
      pulse(3'b001, CMD_DIAG_INIT, s);
      expect_msg(s + d + 2, MSG_DIAG, '0, 1'b1);
      wait_idle();
    end
  endtask

  task automatic t_relay();
    int s;
    set_dly(DLY_SS_START, 0);
    set_dly(DLY_RELAY, 2);
    pulse(3'b010, CMD_NONE, s);
    expect_msg(s + 2, MSG_SYNC_START, '0, 1'b0);
    wait_idle();
    pulse(3'b100, CMD_NONE, s);
    expect_msg(s + 4, MSG_SYNC_RELAY, '0, 1'b0);
    wait_idle();
    wr(REG_CTRL, 32'h2);
    set_dly(DLY_SS_PRES, 1);
    pulse(3'b010, CMD_NONE, s);
    expect_msg(s + 3, MSG_SYNC_START, '0, 1'b0);
    wait_idle();
  endtask

  task automatic t_iface();
    int s;
    wr(REG_CTRL, 32'h1);
    set_dly(DLY_DIAG, 0);
    set_dly(DLY_RELAY, 0);
    pulse(3'b001, CMD_DIAG_INIT, s);
    expect_msg(s + 2, MSG_DIAG, '0, 1'b1);
    // Startup delay 0 is below the least value, so one tick
    expect_msg(s + 3, MSG_SYNC_START, '0, 1'b0);
    wait_idle();
    pulse(3'b010, CMD_NONE, s);
    expect_msg(s + 2, MSG_SYNC_RELAY, '0, 1'b0);
    wait_idle();
    wr(REG_CTRL, 32'h3);
    set_dly(DLY_SS_PRES, 0);
    pulse(3'b001, CMD_SYNC_PRES, s);
    expect_msg(s + 2, MSG_SYNC_START, '0, 1'b0);
    wait_idle();
  endtask

  task automatic t_cd();
    int s;
    wr(REG_CTRL, 32'h0);
    set_dly(DLY_CD_FIRST, 0);
    set_dly(DLY_CD_NEXT, 2);
    pulse(3'b001, CMD_COLL_DIAG, s);
    for (int i = 0; i < 4; i++) begin
      expect_msg(s + 3 + 2 * i, MSG_COLL_DIAG, PAYLOAD_W'(i), 1'b1);
    end
    wait_idle();
  endtask

  task automatic push_s2(input logic [PAYLOAD_W-1:0] d);
    int n;
    @(posedge pclk);
    s2_valid <= 1'b1;
    s2_data <= d;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s2_ready !== 1'b1 && n < 50);
    s2_valid <= 1'b0;
  endtask

  task automatic t_sched();
    logic [31:0] r;
    logic        e;
    int          s;
    wr(REG_COUNT, 32'h0302);
    set_dly(DLY_SU_FIRST, 0);
    set_dly(DLY_SU_S2, 2);
    set_dly(DLY_SCHED_MSG_INTERVAL, 3);
    push_s2(16'hA5C3);
    push_s2(16'h5A3C);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check(32'(r[ST_LVL_LSB +: 4]), 32'h2);
    pulse(3'b001, CMD_SCHED, s);
    expect_msg(s + 3, MSG_SCHED1, 16'h0000, 1'b1);
    expect_msg(s + 6, MSG_SCHED1, 16'h0001, 1'b1);
    expect_msg(s + 8, MSG_SCHED2, 16'hA5C3, 1'b1);
    expect_msg(s + 11, MSG_SCHED2, 16'h5A3C, 1'b1);
    wait_idle();
  endtask

  task automatic t_pe();
    int s;
    int s_busy;
    set_dly(DLY_PE_FIRST, 2);
    set_dly(DLY_PROC_ELEM_MSG_INTERVAL, 0);
    pulse(3'b001, CMD_PROC_ELEM, s);
    // A command while busy must be dropped; wait_idle sees any stray
    pulse(3'b001, CMD_DIAG_INIT, s_busy);
    for (int i = 0; i < 3; i++) begin
      expect_msg(s + 4 + i, MSG_PROC_ELEM, '0, 1'b0);
    end
    wait_idle();
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, cmd_stb, accept_start, accept_relay, s2_valid} = '0;
    paddr = '0;
    pwdata = '0;
    cmd = CMD_NONE;
    s2_data = '0;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_diag();
    t_relay();
    t_iface();
    t_cd();
    t_sched();
    t_pe();
    test_done();
  end
endmodule
